// ### verilog/adc_conv_end.sv
// Converter end: calibration, sample and convert sequence, result hold
//
// How it works
// - Requests refused during calibration or before configuration
// - One-cycle trigger starts sampling then conversion
// - Channel presented with trigger is converted
// - Accepted request raises sampling and busy
// - Sampling falls after hold, busy stays
// - Completion drops busy, raises ready, result
// - Ready holds until next request, clocked fall
// - Result bus held until ready rises again
// - Controller captures result only while ready
// - Calibration runs fixed cycles after reset release
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module adc_conv_end
  import adc_pkg::*;
#(
  parameter int CAL_N    = CAL_CYCLES,
  parameter int SAMPLE_N = SAMPLE_CYCLES,
  parameter int CONV_N   = CONV_CYCLES
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  adc_link_if.conv              link,
  input  wire logic             converter_reset,
  input  wire logic [RES_W-1:0] mux_code,
  output logic      [CH_W-1:0]  mux_channel,
  output logic                  cal_done,
  output logic                  trigger_ignored,
  output logic      [CH_W-1:0]  result_channel
);
  // ==========================================================
  // State
  typedef struct packed {
    conv_state_t      st;
    logic [CH_W-1:0]  chan;
    logic [CH_W-1:0]  res_chan;
    logic [RES_W-1:0] code;
    logic [RES_W-1:0] result;
    logic             sampling;
    logic             busy;
    logic             ready;
    logic             cal_active;
    logic             cal_done;
    logic             ignored;
    logic             cal_arm;
  } conv_t;

  localparam logic [TMR_W-1:0] CAL_LOAD    = TMR_W'(CAL_N - 1);
  localparam logic [TMR_W-1:0] SAMPLE_LOAD = TMR_W'(SAMPLE_N - 1);
  localparam logic [TMR_W-1:0] CONV_LOAD   = TMR_W'(CONV_N - 1);

  conv_t            cv_ff;
  conv_t            nxt_cv;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;

  // ==========================================================
  // Phase timer
  phase_timer #(
    .W        (TMR_W)
  ) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_done)
  );

  // ==========================================================
  // Sequence
  always_comb begin
    nxt_cv         = cv_ff;
    nxt_cv.cal_done = 1'b0;
    nxt_cv.ignored  = 1'b0;
    tmr_load       = 1'b0;
    tmr_val        = CAL_LOAD;
    if (converter_reset || cv_ff.cal_arm) begin
      // Reset held, or first cycle after presetn: reload calibration
      nxt_cv.cal_arm    = 1'b0;
      nxt_cv.st         = ST_CAL;
      nxt_cv.sampling   = 1'b0;
      nxt_cv.busy       = 1'b0;
      nxt_cv.ready      = 1'b0;
      nxt_cv.cal_active = 1'b1;
      tmr_load          = 1'b1;
      tmr_val           = CAL_LOAD;
    end else begin
      case (cv_ff.st)
        ST_CAL: begin
          nxt_cv.cal_active = 1'b1;
          if (link.conv_trigger) begin
            nxt_cv.ignored = 1'b1;
          end
          if (tmr_done) begin
            nxt_cv.st         = ST_IDLE;
            nxt_cv.cal_active = 1'b0;
            nxt_cv.cal_done   = 1'b1;
          end
        end
        ST_IDLE: begin
          if (link.conv_trigger) begin
            nxt_cv.st       = ST_SAMPLE;
            nxt_cv.chan     = link.channel_select;
            nxt_cv.sampling = 1'b1;
            nxt_cv.busy     = 1'b1;
            nxt_cv.ready    = 1'b0;
            tmr_load        = 1'b1;
            tmr_val         = SAMPLE_LOAD;
          end
        end
        ST_SAMPLE: begin
          // Overlapping requests are dropped rather than restarting
          if (link.conv_trigger) begin
            nxt_cv.ignored = 1'b1;
          end
          if (tmr_done) begin
            nxt_cv.st       = ST_CONVERT;
            nxt_cv.code     = mux_code;
            nxt_cv.sampling = 1'b0;
            tmr_load        = 1'b1;
            tmr_val         = CONV_LOAD;
          end
        end
        ST_CONVERT: begin
          if (link.conv_trigger) begin
            nxt_cv.ignored = 1'b1;
          end
          if (tmr_done) begin
            nxt_cv.st       = ST_IDLE;
            nxt_cv.busy     = 1'b0;
            nxt_cv.ready    = 1'b1;
            // Result and its channel change only here
            nxt_cv.result   = cv_ff.code;
            nxt_cv.res_chan = cv_ff.chan;
          end
        end
        default: begin
          nxt_cv.st = ST_CAL;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv_ff            <= '0;
      cv_ff.st         <= ST_CAL;
      cv_ff.cal_active <= 1'b1;
      cv_ff.cal_arm    <= 1'b1;
    end else begin
      cv_ff <= nxt_cv;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state flops
  assign link.sampling     = cv_ff.sampling;
  assign link.busy         = cv_ff.busy;
  assign link.result_ready = cv_ff.ready;
  assign link.result       = cv_ff.result;
  assign link.cal_active   = cv_ff.cal_active;
  assign mux_channel       = cv_ff.chan;
  assign cal_done          = cv_ff.cal_done;
  assign trigger_ignored   = cv_ff.ignored;
  assign result_channel    = cv_ff.res_chan;
endmodule : adc_conv_end

// ### verilog/adc_pkg.sv
// Shared constants and types for the converter handshake pair
package adc_pkg;
  // ==========================================================
  // Widths
  localparam int CH_W          = 5;
  localparam int RES_W         = 12;
  localparam int TMR_W         = 12;
  // ==========================================================
  // Timing counts, in converter clock cycles (pclk)
  localparam int CAL_CYCLES    = 3840;
  localparam int SAMPLE_CYCLES = 4;
  localparam int CONV_CYCLES   = 13;
  // ==========================================================
  // Register offsets, byte addresses
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] START_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF  = 8'h08;
  localparam logic [7:0] RES_OFF   = 8'h0C;
  localparam logic [7:0] ISTAT_OFF = 8'h10;
  localparam logic [7:0] IMASK_OFF = 8'h14;
  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CH_LSB   = 8;
  localparam int START_BIT     = 0;
  localparam int ST_CAL_BIT    = 0;
  localparam int ST_SAMP_BIT   = 1;
  localparam int ST_BUSY_BIT   = 2;
  localparam int ST_RDY_BIT    = 3;
  localparam int EV_DONE_BIT   = 0;
  localparam int EV_CAL_BIT    = 1;
  localparam int EV_REF_BIT    = 2;
  localparam int EV_W          = 3;
  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [EV_W-1:0] IMASK_RST = 3'h0;
  // ==========================================================
  // Converter sequence states, Gray along cal-idle-sample-convert
  typedef enum logic [1:0] {
    ST_CAL     = 2'h0,
    ST_IDLE    = 2'h1,
    ST_SAMPLE  = 2'h3,
    ST_CONVERT = 2'h2
  } conv_state_t;
endpackage : adc_pkg

// ### verilog/adc_link_if.sv
// Handshake wires between the converter and its controlling logic
`timescale 1ns/1ps
interface adc_link_if;
  import adc_pkg::*;
  logic             conv_trigger;
  logic [CH_W-1:0]  channel_select;
  logic             sampling;
  logic             busy;
  logic             result_ready;
  logic [RES_W-1:0] result;
  logic             cal_active;

  modport conv (
    input  conv_trigger,
    input  channel_select,
    output sampling,
    output busy,
    output result_ready,
    output result,
    output cal_active
  );
  modport ctrl (
    output conv_trigger,
    output channel_select,
    input  sampling,
    input  busy,
    input  result_ready,
    input  result,
    input  cal_active
  );
endinterface : adc_link_if

// ### verilog/phase_timer.sv
// Down counter that times one phase of the converter sequence
`timescale 1ns/1ps
module phase_timer #(
  parameter int W = 12
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t tmr_ff;
  tmr_t nxt_tmr;

  always_comb begin
    nxt_tmr = tmr_ff;
    if (load) begin
      nxt_tmr.cnt = load_val;
    end else if (tmr_ff.cnt != '0) begin
      nxt_tmr.cnt = tmr_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign expired = (tmr_ff.cnt == '0);
endmodule : phase_timer

// ### verilog/adc_ctrl_end.sv
// Controller end: APB registers, conversion requests, result capture
`timescale 1ns/1ps
module adc_ctrl_end
  import adc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  adc_link_if.ctrl         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  // ==========================================================
  // State
  typedef struct packed {
    logic             enable;
    logic [CH_W-1:0]  chan;
    logic             trig;
    logic [RES_W-1:0] res;
    logic [EV_W-1:0]  istat;
    logic [EV_W-1:0]  imask;
    logic             cal_q;
    logic             rdy_q;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
    logic             irq;
  } ctl_t;

  ctl_t            c_ff;
  ctl_t            nxt_c;
  logic            setup;
  logic            access;
  logic            mapped;
  logic [EV_W-1:0] ev;
  logic            req;
  logic            ok;

  // ==========================================================
  // Bus decode
  assign setup  = psel && !penable;
  assign access = psel && penable && c_ff.ready;
  always_comb begin
    if (paddr == CTRL_OFF) begin
      mapped = 1'b1;
    end else if (paddr == START_OFF) begin
      mapped = 1'b1;
    end else if (paddr == STAT_OFF) begin
      mapped = 1'b1;
    end else if (paddr == RES_OFF) begin
      mapped = 1'b1;
    end else if (paddr == ISTAT_OFF) begin
      mapped = 1'b1;
    end else if (paddr == IMASK_OFF) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_c       = c_ff;
    nxt_c.trig  = 1'b0;
    nxt_c.ready = setup;
    nxt_c.err   = 1'b0;
    nxt_c.cal_q = link.cal_active;
    nxt_c.rdy_q = link.result_ready;
    req = access && pwrite && mapped && (paddr == START_OFF)
          && pwdata[START_BIT];
    // Refused while calibrating, unconfigured or converting
    ok  = c_ff.enable && !link.cal_active && !link.busy
          && !c_ff.trig;
    ev  = '0;
    if (req && ok) begin
      nxt_c.trig = 1'b1;
    end
    ev[EV_REF_BIT]  = req && !ok;
    ev[EV_CAL_BIT]  = c_ff.cal_q && !link.cal_active;
    ev[EV_DONE_BIT] = link.result_ready && !c_ff.rdy_q;
    if (link.result_ready) begin
      nxt_c.res = link.result;
    end
    if (setup) begin
      nxt_c.err   = !mapped;
      nxt_c.rdata = '0;
      if (!pwrite) begin
        if (paddr == CTRL_OFF) begin
          nxt_c.rdata[CTRL_EN_BIT] = c_ff.enable;
          nxt_c.rdata[CTRL_CH_LSB +: CH_W] = c_ff.chan;
        end else if (paddr == STAT_OFF) begin
          nxt_c.rdata[ST_CAL_BIT]  = link.cal_active;
          nxt_c.rdata[ST_SAMP_BIT] = link.sampling;
          nxt_c.rdata[ST_BUSY_BIT] = link.busy;
          nxt_c.rdata[ST_RDY_BIT]  = link.result_ready;
        end else if (paddr == RES_OFF) begin
          nxt_c.rdata[RES_W-1:0] = c_ff.res;
        end else if (paddr == ISTAT_OFF) begin
          nxt_c.rdata[EV_W-1:0] = c_ff.istat;
        end else if (paddr == IMASK_OFF) begin
          nxt_c.rdata[EV_W-1:0] = c_ff.imask;
        end
      end
    end
    if (access && pwrite && (paddr == CTRL_OFF)) begin
      nxt_c.enable = pwdata[CTRL_EN_BIT];
      // Channel is frozen while a conversion is in flight
      if (!link.busy && !c_ff.trig) begin
        nxt_c.chan = pwdata[CTRL_CH_LSB +: CH_W];
      end
    end
    if (access && pwrite && (paddr == IMASK_OFF)) begin
      nxt_c.imask = pwdata[EV_W-1:0];
    end
    // Read clears only the bits it returned, so a late event survives
    if (access && !pwrite && (paddr == ISTAT_OFF)) begin
      nxt_c.istat = (c_ff.istat & ~c_ff.rdata[EV_W-1:0]) | ev;
    end else begin
      nxt_c.istat = c_ff.istat | ev;
    end
    nxt_c.irq = |(nxt_c.istat & nxt_c.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_ff        <= '0;
      c_ff.enable <= CTRL_RST[CTRL_EN_BIT];
      c_ff.imask  <= IMASK_RST;
      c_ff.cal_q  <= 1'b1;
    end else begin
      c_ff <= nxt_c;
    end
  end

  // ==========================================================
  // Outputs
  assign link.conv_trigger   = c_ff.trig;
  assign link.channel_select = c_ff.chan;
  assign prdata              = c_ff.rdata;
  assign pready              = c_ff.ready;
  assign pslverr             = c_ff.err;
  assign irq                 = c_ff.irq;
endmodule : adc_ctrl_end

// ### verif/adc_link_chk.sv
// Assertions on the converter link
`timescale 1ns/1ps
module adc_link_chk
  import adc_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             conv_trigger,
  input wire logic             sampling,
  input wire logic             busy,
  input wire logic             result_ready,
  input wire logic [RES_W-1:0] result,
  input wire logic             cal_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Controller side
  a_trig_one: assert property (conv_trigger |=> !conv_trigger)
    else $error("trigger longer than one cycle");
  a_cal_no_trig: assert property (cal_active |-> !conv_trigger)
    else $error("trigger during calibration");
  a_busy_no_trig: assert property (busy |-> !conv_trigger)
    else $error("trigger while busy");
  // ==========================================================
  // Converter side
  a_start_flags: assert property (
    conv_trigger |=> sampling && busy && !result_ready)
    else $error("flags wrong after trigger");
  a_sample_len: assert property (
    $rose(sampling) |-> sampling[*4] ##1 (!sampling && busy))
    else $error("sampling phase length wrong");
  a_conv_len: assert property (
    $fell(sampling) |-> busy[*8] ##1 busy[*5] ##1 (!busy && result_ready))
    else $error("conversion length wrong");
  a_ready_hold: assert property (
    result_ready && !conv_trigger |=> result_ready)
    else $error("ready dropped without trigger");
  a_ready_fall: assert property (
    $fell(result_ready) |-> $past(conv_trigger))
    else $error("ready fell without trigger");
  a_result_held: assert property (
    !$rose(result_ready) |-> $stable(result))
    else $error("result changed while held");
  c_done: cover property ($rose(result_ready));
  c_next: cover property (result_ready && conv_trigger);
  c_cal: cover property ($fell(cal_active));
endmodule : adc_link_chk

// ### verif/tb_adc_conversion_handshake.sv
// Bench for the converter handshake pair
`timescale 1ns/1ps
module tb_adc_conversion_handshake;
  import adc_pkg::*;
  localparam int    CALN = 16;
  logic             pclk, presetn, converter_reset, err;
  logic             psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [RES_W-1:0] mux_code, prev;
  logic [CH_W-1:0]  mux_channel, result_channel;
  int               bad_count = 0;
  int               n_compared = 0;
  int               seed, n;
  logic             cal_done, trigger_ignored;
  int               n_cal = 0;
  int               n_ign = 0;
  int               exp_cal = 0;
  logic [RES_W-1:0] exp_q[$];
  adc_link_if link();
  // Short calibration keeps the run brief
  adc_conv_end #(.CAL_N(CALN)) adc_conv_end_i (.pclk(pclk),
    .presetn(presetn), .link(link), .converter_reset(converter_reset),
    .mux_code(mux_code), .mux_channel(mux_channel), .cal_done(cal_done),
    .trigger_ignored(trigger_ignored), .result_channel(result_channel));
  adc_ctrl_end adc_ctrl_end_i (.pclk(pclk), .presetn(presetn),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  adc_link_chk adc_link_chk_i (.pclk(pclk), .presetn(presetn),
    .conv_trigger(link.conv_trigger), .sampling(link.sampling),
    .busy(link.busy), .result_ready(link.result_ready),
    .result(link.result), .cal_active(link.cal_active));
  always #2 pclk = ~pclk;
  // Pulse counters for the converter's side outputs
  always @(posedge pclk) begin
    if (cal_done === 1'h1) n_cal++;
    if (trigger_ignored === 1'h1) n_ign++;
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task cal_wait;
    n = 0;
    @(negedge pclk);
    while (link.cal_active === 1'h1 && n < 99) begin
      n++;
      @(negedge pclk);
    end
    chk(n >= CALN - 1 && n <= CALN + 1, 1, "cal length");
    apb(1'h0, ISTAT_OFF, 32'h0);
    chk(rd, 32'h2, "cal event");
    exp_cal++;
    chk(n_cal, exp_cal, "cal done pulse");
  endtask : cal_wait
  // Code is held over the whole conversion, so sampling time is free
  task conv(input int c, input bit dbl);
    logic [RES_W-1:0] v;
    v = RES_W'($random(seed));
    @(posedge pclk);
    mux_code <= v;
    exp_q.push_back(v);
    apb(1'h1, CTRL_OFF, 32'h1 | (32'(c) << CTRL_CH_LSB));
    apb(1'h0, CTRL_OFF, 32'h0);
    chk(rd, 32'h1 | (32'(c) << CTRL_CH_LSB), "ctrl readback");
    apb(1'h1, START_OFF, 32'h1);
    if (dbl) apb(1'h1, START_OFF, 32'h1);
    n = 0;
    @(negedge pclk);
    while (link.busy !== 1'h1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk(link.busy, 1'h1, "busy high");
    chk(mux_channel, c, "channel");
    chk(link.result, prev, "held result");
    chk(link.result_ready, 1'h0, "ready low");
    while (link.result_ready !== 1'h1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk(link.result_ready, 1'h1, "ready rose");
    prev = exp_q.pop_front();
    chk(link.result, prev, "result");
    chk(link.busy, 1'h0, "busy low");
    chk(result_channel, c, "result channel");
    apb(1'h0, RES_OFF, 32'h0);
    chk(rd, prev, "captured result");
    apb(1'h0, STAT_OFF, 32'h0);
    chk(rd, 32'h1 << ST_RDY_BIT, "status ready");
  endtask : conv
  task results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // ==========================================================
  // Sequence
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    converter_reset = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mux_code = 12'h0;
    prev = 12'h0;
    seed = 72697;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    cal_wait();
    apb(1'h1, START_OFF, 32'h1);
    apb(1'h0, ISTAT_OFF, 32'h0);
    chk(rd, 32'h4, "start refused");
    chk(link.busy, 1'h0, "no start");
    converter_reset <= 1'h1;
    repeat (2) @(posedge pclk);
    converter_reset <= 1'h0;
    cal_wait();
    $display("test calibration done");
    apb(1'h1, IMASK_OFF, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) apb(1'h1, IMASK_OFF, 32'h0);
      conv($random(seed) & 31, i == 4);
      @(negedge pclk);
      chk(irq, i < 4, "irq level");
      apb(1'h0, ISTAT_OFF, 32'h0);
      chk(rd, i < 4 ? 32'h1 : 32'h5, "event bits");
      @(negedge pclk);
      chk(irq, 1'h0, "irq cleared");
    end
    $display("test conversions done");
    apb(1'h0, 8'h18, 32'h0);
    chk(err, 1'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    chk(n_ign, 0, "no ignored trigger");
    $display("test unmapped done");
    results();
  end
endmodule : tb_adc_conversion_handshake
